// file: rtl/nsli_defs.svh
// constants for the network status indicator block
`ifndef NSLI_DEFS_SVH
`define NSLI_DEFS_SVH

// blink half period in milliseconds and its length in ref_clk cycles
`define NSLI_BLINK_HALF_MS 250
`define NSLI_CLK_MHZ 250
`define NSLI_BLINK_HALF_CYC (`NSLI_BLINK_HALF_MS * 1000 * `NSLI_CLK_MHZ)
// activity stretch in microseconds and cycles
`define NSLI_ACT_HOLD_US 1000
`define NSLI_ACT_HOLD_CYC (`NSLI_ACT_HOLD_US * `NSLI_CLK_MHZ)
// indicator colour codes: bit 0 green, bit 1 red
`define NSLI_LED_OFF 2'h0
`define NSLI_LED_GREEN 2'h1
`define NSLI_LED_RED 2'h2
// number of network ports
`define NSLI_PORTS 2

`endif

// file: rtl/nsli_pkg.sv
// types for the network status indicator block
package nsli_pkg;
    // display pattern, ordered by severity
    typedef enum logic [2:0] {
        NSLI_PAT_OFF = 3'h0,
        NSLI_PAT_GREEN_FLASH = 3'h1,
        NSLI_PAT_GREEN = 3'h2,
        NSLI_PAT_RED_FLASH = 3'h3,
        NSLI_PAT_RED = 3'h4
    } nsli_pat_t;
endpackage

// file: rtl/nsli_port_led.sv
// link and activity indicators for one network port
`timescale 1ns/10ps
`include "nsli_defs.svh"
module nsli_port_led #(
    parameter int ACT_HOLD = `NSLI_ACT_HOLD_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic link_up,
    input wire logic link_fast,
    input wire logic activity,
    input wire logic blink,
    output logic green_led,
    output logic orange_led
);
    logic [31:0] hold_q;
    logic [31:0] hold_d;
    logic busy;
    logic green_d;
    logic orange_d;

    // stretch short activity pulses so they are visible
    assign hold_d = (activity && link_up) ? ACT_HOLD[31:0] : ((hold_q != 32'h0) ? hold_q - 32'h1 : 32'h0);
    assign busy = (hold_q != 32'h0);
    assign green_d = link_up && link_fast && (!busy || blink);
    assign orange_d = link_up && !link_fast && (!busy || blink);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hold_q <= 32'h0;
            green_led <= 1'b0;
            orange_led <= 1'b0;
        end else begin
            hold_q <= hold_d;
            green_led <= green_d;
            orange_led <= orange_d;
        end
    end
endmodule

// file: rtl/nsli_top.sv
// status indicator logic for an industrial ethernet module
//
// Overview of operation
// - network indicator dark without power or without an assigned ip address.
// - network indicator steady green when online with a class 1 or 3 connection.
// - network indicator flashes green when online with no connection.
// - network indicator steady red on duplicate ip address or fatal error while an ip address is assigned.
// - network indicator flashes red when class 1 or 3 connections timed out.
// - module indicator dark without power, or configured with no fault while originator neither idles nor runs synced.
// - module indicator steady green when originator runs, and synced if sync enabled.
// - module indicator flashes green when unconfigured or originator idle.
// - module indicator steady red on major fault: exception or fatal error.
// - module indicator flashes red on recoverable fault, e.g. stored parameters differ.
// - per port green led: off no link, on 100 Mbps link, flashing on activity.
// - per port orange led: off no link, on 10 Mbps link, flashing on activity.
// - traffic accepted on either port, the other port passes traffic through.
`timescale 1ns/10ps
`include "nsli_defs.svh"
module nsli_top #(
    parameter int BLINK_HALF = `NSLI_BLINK_HALF_CYC,
    parameter int ACT_HOLD = `NSLI_ACT_HOLD_CYC,
    parameter int DW = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    // network state inputs
    input wire logic ip_assigned,
    input wire logic conn_established,
    input wire logic conn_timed_out,
    input wire logic dup_ip,
    input wire logic fatal_error,
    // module state inputs
    input wire logic configured,
    input wire logic orig_run,
    input wire logic orig_idle,
    input wire logic time_sync_feature,
    input wire logic gm_synced,
    input wire logic exception_state,
    input wire logic param_mismatch,
    input wire logic recoverable_fault,
    // port link status
    input wire logic p0_link_up,
    input wire logic p0_link_fast,
    input wire logic p1_link_up,
    input wire logic p1_link_fast,
    // port traffic, byte wide with valid
    input wire logic [DW-1:0] p0_rx_data,
    input wire logic p0_rx_valid,
    input wire logic [DW-1:0] p1_rx_data,
    input wire logic p1_rx_valid,
    output logic [DW-1:0] p0_tx_data,
    output logic p0_tx_valid,
    output logic [DW-1:0] p1_tx_data,
    output logic p1_tx_valid,
    // traffic seen by the protocol stack
    output logic [DW-1:0] host_rx_data,
    output logic host_rx_valid,
    output logic host_rx_port,
    // indicators, bit 0 green, bit 1 red
    output logic [1:0] network_state_indicator,
    output logic [1:0] module_state_indicator,
    output logic p0_green_led,
    output logic p0_orange_led,
    output logic p1_green_led,
    output logic p1_orange_led
);
    // ==========================================================
    // blink timer
    logic [31:0] blink_cnt_q;
    logic [31:0] blink_cnt_d;
    logic blink_q;
    logic blink_d;
    logic blink_wrap;

    assign blink_wrap = (blink_cnt_q >= BLINK_HALF[31:0] - 32'h1);
    assign blink_cnt_d = blink_wrap ? 32'h0 : blink_cnt_q + 32'h1;
    assign blink_d = blink_wrap ? !blink_q : blink_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            blink_cnt_q <= 32'h0;
            blink_q <= 1'b1;
        end else begin
            blink_cnt_q <= blink_cnt_d;
            blink_q <= blink_d;
        end
    end

    // ==========================================================
    // network state pattern
    nsli_pkg::nsli_pat_t ns_pat;
    nsli_pkg::nsli_pat_t ms_pat;
    logic ms_green_ok;

    // priority chain puts a missing address first, then the most severe condition
    assign ns_pat = !ip_assigned ? nsli_pkg::NSLI_PAT_OFF :
                    (dup_ip || fatal_error) ? nsli_pkg::NSLI_PAT_RED :
                    conn_timed_out ? nsli_pkg::NSLI_PAT_RED_FLASH :
                    conn_established ? nsli_pkg::NSLI_PAT_GREEN :
                    nsli_pkg::NSLI_PAT_GREEN_FLASH;

    // ==========================================================
    // module state pattern
    assign ms_green_ok = orig_run && (!time_sync_feature || gm_synced);
    assign ms_pat = (exception_state || fatal_error) ? nsli_pkg::NSLI_PAT_RED :
                    (recoverable_fault || (configured && param_mismatch)) ?
                        nsli_pkg::NSLI_PAT_RED_FLASH :
                    (!configured || orig_idle) ? nsli_pkg::NSLI_PAT_GREEN_FLASH :
                    ms_green_ok ? nsli_pkg::NSLI_PAT_GREEN :
                    nsli_pkg::NSLI_PAT_OFF;

    function automatic logic [1:0] nsli_colour(input nsli_pkg::nsli_pat_t pat, input logic blink);
        logic [1:0] c;
        c = `NSLI_LED_OFF;
        case (pat)
            nsli_pkg::NSLI_PAT_GREEN: c = `NSLI_LED_GREEN;
            nsli_pkg::NSLI_PAT_GREEN_FLASH: c = blink ? `NSLI_LED_GREEN : `NSLI_LED_OFF;
            nsli_pkg::NSLI_PAT_RED: c = `NSLI_LED_RED;
            nsli_pkg::NSLI_PAT_RED_FLASH: c = blink ? `NSLI_LED_RED : `NSLI_LED_OFF;
            default: c = `NSLI_LED_OFF;
        endcase
        return c;
    endfunction

    logic [1:0] ns_led_d;
    logic [1:0] ms_led_d;
    assign ns_led_d = nsli_colour(ns_pat, blink_q);
    assign ms_led_d = nsli_colour(ms_pat, blink_q);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            network_state_indicator <= `NSLI_LED_OFF;
            module_state_indicator <= `NSLI_LED_OFF;
        end else begin
            network_state_indicator <= ns_led_d;
            module_state_indicator <= ms_led_d;
        end
    end

    // ==========================================================
    // port link and activity indicators
    logic p0_act;
    logic p1_act;

    // bytes in either direction count as activity
    assign p0_act = p0_rx_valid || p0_tx_valid;
    assign p1_act = p1_rx_valid || p1_tx_valid;

    nsli_port_led #(.ACT_HOLD(ACT_HOLD)) u_p0_led (
        .ref_clk(ref_clk),
        .rst(rst),
        .link_up(p0_link_up),
        .link_fast(p0_link_fast),
        .activity(p0_act),
        .blink(blink_q),
        .green_led(p0_green_led),
        .orange_led(p0_orange_led)
    );

    nsli_port_led #(.ACT_HOLD(ACT_HOLD)) u_p1_led (
        .ref_clk(ref_clk),
        .rst(rst),
        .link_up(p1_link_up),
        .link_fast(p1_link_fast),
        .activity(p1_act),
        .blink(blink_q),
        .green_led(p1_green_led),
        .orange_led(p1_orange_led)
    );

    // ==========================================================
    // passthrough and host delivery
    logic p0_in;
    logic p1_in;
    logic p0_fwd_d;
    logic p1_fwd_d;
    logic host_valid_d;
    logic host_port_d;
    logic [DW-1:0] host_data_d;

    // a byte counts only when its own port has link
    assign p0_in = p0_rx_valid && p0_link_up;
    assign p1_in = p1_rx_valid && p1_link_up;
    // forwarding also needs link on the far port
    assign p1_fwd_d = p0_in && p1_link_up;
    assign p0_fwd_d = p1_in && p0_link_up;
    // port 0 has priority when both deliver in one cycle
    assign host_valid_d = p0_in || p1_in;
    assign host_port_d = !p0_in && p1_in;
    assign host_data_d = p0_in ? p0_rx_data : p1_rx_data;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            p1_tx_data <= '0;
            p1_tx_valid <= 1'b0;
        end else begin
            p1_tx_data <= p0_rx_data;
            p1_tx_valid <= p1_fwd_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            p0_tx_data <= '0;
            p0_tx_valid <= 1'b0;
        end else begin
            p0_tx_data <= p1_rx_data;
            p0_tx_valid <= p0_fwd_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            host_rx_data <= '0;
            host_rx_valid <= 1'b0;
            host_rx_port <= 1'b0;
        end else begin
            host_rx_data <= host_data_d;
            host_rx_valid <= host_valid_d;
            host_rx_port <= host_port_d;
        end
    end
endmodule

// file: dv/nsli_asserts.sv
// checker for the status indicator block
`timescale 1ns/10ps
module nsli_asserts #(
    parameter int DW = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ip_assigned,
    input wire logic conn_established,
    input wire logic conn_timed_out,
    input wire logic dup_ip,
    input wire logic fatal_error,
    input wire logic exception_state,
    input wire logic p0_link_up,
    input wire logic p0_link_fast,
    input wire logic p1_link_up,
    input wire logic [DW-1:0] p0_rx_data,
    input wire logic p0_rx_valid,
    input wire logic [DW-1:0] p1_tx_data,
    input wire logic p1_tx_valid,
    input wire logic [DW-1:0] host_rx_data,
    input wire logic host_rx_valid,
    input wire logic host_rx_port,
    input wire logic [1:0] network_state_indicator,
    input wire logic [1:0] module_state_indicator,
    input wire logic p0_green_led,
    input wire logic p0_orange_led
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic net_ok = ip_assigned && !dup_ip && !fatal_error;
    // ====
    // indicators, passthrough and host delivery
    a_net_dark: assert property (!ip_assigned |=> network_state_indicator == 2'h0)
        else $error("network indicator lit without address");
    a_net_red: assert property (ip_assigned && (dup_ip || fatal_error) |=> network_state_indicator == 2'h2)
        else $error("network indicator not red");
    a_net_green: assert property (net_ok && !conn_timed_out && conn_established |=>
        network_state_indicator == 2'h1)
        else $error("network indicator not green");
    a_net_timeout: assert property (net_ok && conn_timed_out |=> network_state_indicator inside {2'h0, 2'h2})
        else $error("network indicator wrong on timeout");
    a_mod_major: assert property (exception_state || fatal_error |=> module_state_indicator == 2'h2)
        else $error("module indicator not red");
    a_led_nolink: assert property (!p0_link_up |=> !p0_green_led && !p0_orange_led)
        else $error("port led lit without link");
    a_led_fast: assert property (p0_link_up && p0_link_fast |=> !p0_orange_led)
        else $error("orange led lit on fast link");
    a_fwd_pass: assert property (p0_rx_valid && p0_link_up && p1_link_up |=>
        p1_tx_valid && p1_tx_data == $past(p0_rx_data))
        else $error("byte not passed through");
    a_host_take: assert property (p0_rx_valid && p0_link_up |=>
        host_rx_valid && !host_rx_port && host_rx_data == $past(p0_rx_data))
        else $error("byte not delivered to stack");
    c_fwd: cover property (p0_rx_valid ##1 p1_tx_valid);
    c_red: cover property (network_state_indicator == 2'h2);
    c_flash: cover property (module_state_indicator == 2'h2 ##1 module_state_indicator == 2'h0);
endmodule

// file: dv/nsli_orig_model.sv
// originator model sending one implicit frame on a port
`timescale 1ns/10ps
module nsli_orig_model (
    input wire logic ref_clk,
    input wire logic start,
    input wire logic sel,
    output logic [7:0] p0_rx_data,
    output logic p0_rx_valid,
    output logic [7:0] p1_rx_data,
    output logic p1_rx_valid
);
    logic go_q;
    logic vld_q;
    logic [2:0] idx_q;
    logic [7:0] byte_q = 8'h5a;
    initial idx_q = 3'h0;
    always @(posedge ref_clk) go_q <= start;
    // four header bytes, run bit set, then four payload bytes
    always @(negedge ref_clk) begin
        if (go_q || idx_q != 3'h0) begin
            idx_q <= idx_q + 3'h1;
            byte_q <= (idx_q == 3'h0) ? 8'h01 : ((idx_q < 3'h4) ? 8'h00 : {5'h00, idx_q} + 8'h10);
            vld_q <= 1'b1;
        end else begin
            byte_q <= ~byte_q;
            vld_q <= 1'b0;
        end
    end
    assign p0_rx_data = sel ? ~byte_q : byte_q;
    assign p1_rx_data = sel ? byte_q : ~byte_q;
    assign p0_rx_valid = vld_q === 1'b1 && !sel;
    assign p1_rx_valid = vld_q === 1'b1 && sel;
endmodule

// file: dv/testbench.sv
// self-checking testbench for the status indicator block
`timescale 1ns/10ps
module testbench;
    logic ref_clk, rst, start, sel, host_rx_valid, host_rx_port, p0_tx_valid, p1_tx_valid, p0_rx_valid, p1_rx_valid;
    logic ip_assigned, conn_established, conn_timed_out, dup_ip, fatal_error, configured, orig_run, orig_idle;
    logic time_sync_feature, gm_synced, exception_state, param_mismatch, recoverable_fault;
    logic p0_link_up, p0_link_fast, p1_link_up, p1_link_fast, p0_green_led, p0_orange_led, p1_green_led, p1_orange_led;
    logic [7:0] p0_rx_data, p1_rx_data, p0_tx_data, p1_tx_data, host_rx_data;
    logic [1:0] network_state_indicator, module_state_indicator;
    logic [12:0] st;
    logic [2:0] ns_seen, ms_seen;
    logic [18:0] rows [8] = '{{13'h0000, 3'h1, 3'h3}, {13'h18c0, 3'h2, 3'h2}, {13'h10a0, 3'h3, 3'h3},
        {13'h1ac4, 3'h4, 3'h4}, {13'h1c82, 3'h5, 3'h5}, {13'h14d0, 3'h5, 3'h1}, {13'h18d9, 3'h2, 3'h5},
        {13'h1d80, 3'h4, 3'h4}};
    int fail_count = 0;
    int num_checks = 0;
    int n, m;
    assign {ip_assigned, conn_established, conn_timed_out, dup_ip, fatal_error, configured, orig_run, orig_idle,
        time_sync_feature, gm_synced, exception_state, param_mismatch, recoverable_fault} = st;
    nsli_top #(.BLINK_HALF(8), .ACT_HOLD(5), .DW(8)) DUT (.*);
    nsli_orig_model PARTNER (.*);
    // ====
    // tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic run_len(input logic [1:0] v, output int len);
        len = 0;
        while (network_state_indicator === v && len < 40) begin
            @(negedge ref_clk);
            len++;
        end
    endtask
    task automatic frame(input logic port, input int fwd);
        logic dark;
        dark = 1'b0;
        sel = port;
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        n = 0;
        m = 0;
        repeat (12) begin
            @(negedge ref_clk);
            if ((port ? p1_orange_led : p0_green_led) === 1'b0) dark = 1'b1;
            if (p0_tx_valid === 1'b1 || p1_tx_valid === 1'b1) begin
                m++;
                if (m == 1) check(port ? p0_tx_data : p1_tx_data, 8'h01);
            end
            if (host_rx_valid === 1'b1) begin
                n++;
                if (n == 1) check({host_rx_data[6:0], host_rx_port}, {7'h01, port});
            end
        end
        check(8'(n), 8'h08);
        check(8'(m), 8'(fwd));
        check({7'h00, dark}, 8'h01);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        #20000;
        fail_count++;
        complete_run();
    end
    // ====
    // main sequence
    initial begin
        {st, p0_link_up, p0_link_fast, p1_link_up, p1_link_fast, start, sel, rst} = 20'h00001;
        repeat (8) @(negedge ref_clk);
        check({network_state_indicator, module_state_indicator, p0_green_led, p0_orange_led, p1_green_led,
            p1_orange_led}, 8'h00);
        rst = 1'b0;
        foreach (rows[i]) begin
            st = rows[i][18:6];
            repeat (2) @(negedge ref_clk);
            {ns_seen, ms_seen} = 6'h00;
            repeat (16) begin
                @(negedge ref_clk);
                ns_seen[network_state_indicator] = 1'b1;
                ms_seen[module_state_indicator] = 1'b1;
            end
            check({5'h00, ns_seen}, {5'h00, rows[i][5:3]});
            check({5'h00, ms_seen}, {5'h00, rows[i][2:0]});
        end
        st = 13'h1000;
        repeat (2) @(negedge ref_clk);
        run_len(2'h1, n);
        run_len(2'h0, n);
        run_len(2'h1, n);
        check(8'(n), 8'h08);
        run_len(2'h0, n);
        check(8'(n), 8'h08);
        {p0_link_up, p0_link_fast, p1_link_up, p1_link_fast} = 4'he;
        repeat (2) @(negedge ref_clk);
        check({4'h0, p0_green_led, p0_orange_led, p1_green_led, p1_orange_led}, 8'h09);
        frame(1'b0, 8);
        frame(1'b1, 8);
        p1_link_up = 1'b0;
        frame(1'b0, 0);
        p0_link_up = 1'b0;
        repeat (2) @(negedge ref_clk);
        check({6'h00, p0_green_led, p0_orange_led}, 8'h00);
        // reset in mid-run, then the blink phase must restart lit
        st = 13'h1000;
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        check({network_state_indicator, module_state_indicator, host_rx_valid, p0_tx_valid, p1_tx_valid,
            p0_green_led}, 8'h00);
        rst = 1'b0;
        @(negedge ref_clk);
        run_len(2'h1, n);
        check(8'(n), 8'h08);
        complete_run();
    end
endmodule
bind nsli_top nsli_asserts #(.DW(DW)) u_chk (.*);
